// *** shared/hpcb_pkg.sv ***
// Constants and types for the hub port configuration bank.
// Assumes an 8-bit configuration address/data port on one core clock.
package hpcb_pkg;

    // ****************************************************
    // Register offsets
    // ****************************************************
    localparam logic [7:0] OFS_UP_BOOST    = 8'h31;
    localparam logic [7:0] OFS_DN_BOOST    = 8'h33;
    localparam logic [7:0] OFS_SWAP        = 8'h35;
    localparam logic [7:0] OFS_REMAP12     = 8'h36;
    localparam logic [7:0] OFS_REMAP3      = 8'h37;
    localparam logic [7:0] OFS_CMD         = 8'h39;
    localparam logic [7:0] OFS_PROT_LAST   = 8'hFE;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int UP_BOOST_LSB  = 0;
    localparam int P3_BOOST_LSB  = 4;
    localparam int P2_BOOST_LSB  = 2;
    localparam int SWAP_UP_BIT   = 0;
    localparam int SWAP_P2_BIT   = 2;
    localparam int SWAP_P3_BIT   = 3;
    localparam int MAP_HI_LSB    = 4;
    localparam int MAP_LO_LSB    = 0;
    localparam int CMD_ATTACH    = 0;
    localparam int CMD_SOFT_RST  = 1;

    // ****************************************************
    // Writable masks and reset values
    // ****************************************************
    localparam logic [7:0] MSK_UP_BOOST  = 8'h03;
    localparam logic [7:0] MSK_DN_BOOST  = 8'h3C;
    localparam logic [7:0] MSK_SWAP      = 8'h0D;
    localparam logic [7:0] MSK_REMAP12   = 8'hFF;
    localparam logic [7:0] MSK_REMAP3    = 8'h0F;
    localparam logic [7:0] RST_UP_BOOST  = 8'h00;
    localparam logic [7:0] RST_DN_BOOST  = 8'h00;
    localparam logic [7:0] RST_SWAP      = 8'h00;
    localparam logic [7:0] RST_REMAP12   = 8'h21;
    localparam logic [7:0] RST_REMAP3    = 8'h03;
    localparam logic       RST_ATTACH    = 1'b1;

    // ****************************************************
    // Codes
    // ****************************************************
    localparam logic [3:0] MAP_DISABLED  = 4'h0;
    localparam logic [3:0] MAP_MAX       = 4'h3;

    typedef enum logic [3:0] {
        HPCB_DRV_NORMAL = 4'h1,
        HPCB_DRV_P4     = 4'h2,
        HPCB_DRV_P8     = 4'h4,
        HPCB_DRV_P12    = 4'h8
    } hpcb_drive_t;

endpackage

// *** design/hpcb_bank.sv ***
// Hub port configuration register bank: boost, pin swap, port remap, command.
// Assumes the loader or firmware drives the address/write port on core_clk;
// the reset pin arrives asynchronously and is synchronised here.
//
// How it works
// - Upstream boost code lives in bits 1:0 at 31h, resets normal, rest zero.
// - Port 3 boost code lives in bits 5:4 at 33h, resets normal.
// - Port 2 boost code lives in bits 3:2 at 33h; bits 7:6, 1:0 reserved.
// - Code 00 normal drive; 01, 10, 11 give +4, +8, +12 percent.
// - Swap bit one puts D+ on the minus pin and D- on the plus pin.
// - Swap bit 0 upstream, bit 2 port 2, bit 3 port 3; reset zero.
// - Remap 36h: bits 7:4 physical 2, 3:0 physical 1; 0 disables.
// - Remap 37h: bits 3:0 physical 3, upper bits reserved, reset 03h.
// - Remap tables steer logical numbering only when remap is enabled.
// - Command bit 1 restores defaults, but 39h lies in the protected range and attach resets to one, so that write never lands.
// - With attach bit zero the hub stays in configuration, not attached.
// - Attach bit one signals attach and blocks writes to 00h through FEh.
// - Attach bit is never written, as 39h is protected while it is one; pin or power-on reset sets it to one.
// - Remap enable zero: standard mode with shifting; one: remap tables.
`timescale 1ns/100ps
module hpcb_bank (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       external_reset_n,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    input  wire logic       remap_enable,
    input  wire logic [2:0] std_port_disable,
    output logic      [1:0] upstream_boost_code,
    output logic      [1:0] port2_boost_code,
    output logic      [1:0] port3_boost_code,
    output logic      [3:0] upstream_drive_sel,
    output logic      [3:0] port2_drive_sel,
    output logic      [3:0] port3_drive_sel,
    output logic      [2:0] pin_swap_bits,
    input  wire logic [2:0] tx_dp,
    input  wire logic [2:0] tx_dm,
    output logic      [2:0] diff_plus_pin,
    output logic      [2:0] diff_minus_pin,
    output logic      [3:0] remap_ports_one_two_field,
    output logic      [3:0] remap_port_two_field,
    output logic      [3:0] remap_port_three_field,
    output logic      [1:0] phys1_logical,
    output logic      [1:0] phys2_logical,
    output logic      [1:0] phys3_logical,
    output logic            usb_attach,
    output logic            config_state
);

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic [3:0] drive_dec(input logic [1:0] c);
        unique case (c)
            2'h0: drive_dec = hpcb_pkg::HPCB_DRV_NORMAL;
            2'h1: drive_dec = hpcb_pkg::HPCB_DRV_P4;
            2'h2: drive_dec = hpcb_pkg::HPCB_DRV_P8;
            2'h3: drive_dec = hpcb_pkg::HPCB_DRV_P12;
        endcase
    endfunction

    // Reserved codes are treated as disabled so the host never sees them
    function automatic logic [1:0] map_dec(input logic [3:0] m);
        if (m == hpcb_pkg::MAP_DISABLED || m > hpcb_pkg::MAP_MAX) begin
            map_dec = 2'h0;
        end else begin
            map_dec = m[1:0];
        end
    endfunction

    // ****************************************************
    // Reset pin synchroniser
    // ****************************************************
    logic ext_n_s1_r;
    logic ext_n_s2_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_n_s1_r <= 1'b0;
            ext_n_s2_r <= 1'b0;
        end else begin
            ext_n_s1_r <= external_reset_n;
            ext_n_s2_r <= ext_n_s1_r;
        end
    end
    // Hard reset: power-on (sys_rst) or the synchronised pin
    wire hard_rst = sys_rst | ~ext_n_s2_r;

    // ****************************************************
    // Register file
    // ****************************************************
    logic [7:0] up_boost_r;
    logic [7:0] dn_boost_r;
    logic [7:0] swap_r;
    logic [7:0] remap12_r;
    logic [7:0] remap3_r;
    logic       attach_r;
    logic       attach_wr_done_r;

    // Protection covers 00h..FEh; FFh stays writable
    wire wr_prot  = attach_r && (cfg_addr <= hpcb_pkg::OFS_PROT_LAST);
    wire wr_ok    = cfg_wr && !wr_prot;
    wire wr_up    = wr_ok && cfg_addr == hpcb_pkg::OFS_UP_BOOST;
    wire wr_dn    = wr_ok && cfg_addr == hpcb_pkg::OFS_DN_BOOST;
    wire wr_swap  = wr_ok && cfg_addr == hpcb_pkg::OFS_SWAP;
    wire wr_r12   = wr_ok && cfg_addr == hpcb_pkg::OFS_REMAP12;
    wire wr_r3    = wr_ok && cfg_addr == hpcb_pkg::OFS_REMAP3;
    wire wr_cmd   = wr_ok && cfg_addr == hpcb_pkg::OFS_CMD;
    // Soft reset pulse; the bit itself is never stored, so it reads zero
    wire soft_rst = wr_cmd && cfg_wdata[hpcb_pkg::CMD_SOFT_RST];
    wire att_wr   = wr_cmd && !attach_wr_done_r;

    always_ff @(posedge core_clk) begin
        if (hard_rst || soft_rst) begin
            up_boost_r <= hpcb_pkg::RST_UP_BOOST;
            dn_boost_r <= hpcb_pkg::RST_DN_BOOST;
            swap_r     <= hpcb_pkg::RST_SWAP;
            remap12_r  <= hpcb_pkg::RST_REMAP12;
            remap3_r   <= hpcb_pkg::RST_REMAP3;
        end else begin
            if (wr_up) begin
                up_boost_r <= cfg_wdata & hpcb_pkg::MSK_UP_BOOST;
            end
            if (wr_dn) begin
                dn_boost_r <= cfg_wdata & hpcb_pkg::MSK_DN_BOOST;
            end
            if (wr_swap) begin
                swap_r <= cfg_wdata & hpcb_pkg::MSK_SWAP;
            end
            if (wr_r12) begin
                remap12_r <= cfg_wdata & hpcb_pkg::MSK_REMAP12;
            end
            if (wr_r3) begin
                remap3_r <= cfg_wdata & hpcb_pkg::MSK_REMAP3;
            end
        end
    end

    // Attach survives soft reset; only pin or power-on sets it back to one
    always_ff @(posedge core_clk) begin
        if (hard_rst) begin
            attach_r         <= hpcb_pkg::RST_ATTACH;
            attach_wr_done_r <= 1'b0;
        end else if (att_wr) begin
            attach_r         <= cfg_wdata[hpcb_pkg::CMD_ATTACH];
            attach_wr_done_r <= 1'b1;
        end
    end

    // ****************************************************
    // Read mux
    // ****************************************************
    logic [7:0] rdata_nxt;
    always_comb begin
        unique case (cfg_addr)
            hpcb_pkg::OFS_UP_BOOST: rdata_nxt = up_boost_r;
            hpcb_pkg::OFS_DN_BOOST: rdata_nxt = dn_boost_r;
            hpcb_pkg::OFS_SWAP:     rdata_nxt = swap_r;
            hpcb_pkg::OFS_REMAP12:  rdata_nxt = remap12_r;
            hpcb_pkg::OFS_REMAP3:   rdata_nxt = remap3_r;
            hpcb_pkg::OFS_CMD:      rdata_nxt = {7'h00, attach_r};
            default:                rdata_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= rdata_nxt;
        end
    end

    // ****************************************************
    // Drive strength, pin swap
    // ****************************************************
    assign upstream_boost_code = up_boost_r[hpcb_pkg::UP_BOOST_LSB +: 2];
    assign port3_boost_code = dn_boost_r[hpcb_pkg::P3_BOOST_LSB +: 2];
    assign port2_boost_code = dn_boost_r[hpcb_pkg::P2_BOOST_LSB +: 2];
    assign upstream_drive_sel = drive_dec(upstream_boost_code);
    assign port2_drive_sel    = drive_dec(port2_boost_code);
    assign port3_drive_sel    = drive_dec(port3_boost_code);

    assign pin_swap_bits = {swap_r[hpcb_pkg::SWAP_P3_BIT],
                            swap_r[hpcb_pkg::SWAP_P2_BIT],
                            swap_r[hpcb_pkg::SWAP_UP_BIT]};
    // Per-port crossbar; index 0 upstream, 1 port 2, 2 port 3
    assign diff_plus_pin  = (tx_dm & pin_swap_bits)
                          | (tx_dp & ~pin_swap_bits);
    assign diff_minus_pin = (tx_dp & pin_swap_bits)
                          | (tx_dm & ~pin_swap_bits);

    // ****************************************************
    // Port numbering
    // ****************************************************
    assign remap_ports_one_two_field = remap12_r[hpcb_pkg::MAP_LO_LSB +: 4];
    assign remap_port_two_field      = remap12_r[hpcb_pkg::MAP_HI_LSB +: 4];
    assign remap_port_three_field    = remap3_r[hpcb_pkg::MAP_LO_LSB +: 4];

    // Standard mode: enabled ports keep order, higher ones shift down
    wire [1:0] std1 = std_port_disable[0] ? 2'h0 : 2'h1;
    wire [1:0] std2 = std_port_disable[1] ? 2'h0 :
                      (std_port_disable[0] ? 2'h1 : 2'h2);
    wire [1:0] std3 = std_port_disable[2] ? 2'h0 :
                      2'h3 - {1'h0, std_port_disable[0]}
                           - {1'h0, std_port_disable[1]};
    // Remap tables assume contiguous programming and are not checked
    assign phys1_logical = remap_enable ?
                           map_dec(remap_ports_one_two_field) : std1;
    assign phys2_logical = remap_enable ?
                           map_dec(remap_port_two_field) : std2;
    assign phys3_logical = remap_enable ?
                           map_dec(remap_port_three_field) : std3;

    // ****************************************************
    // Attach
    // ****************************************************
    assign usb_attach   = attach_r;
    assign config_state = !attach_r;

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_soft;
        soft_rst;
    endsequence
    property p_soft_defaults;
        @(posedge core_clk) disable iff (sys_rst)
        s_soft ##1 !hard_rst |-> remap12_r == hpcb_pkg::RST_REMAP12
            && remap3_r == hpcb_pkg::RST_REMAP3 && swap_r == 8'h00;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults)
        else $error("soft reset did not restore defaults");

    property p_prot;
        @(posedge core_clk) disable iff (hard_rst)
        attach_r && cfg_wr |=> $stable(up_boost_r) && $stable(remap12_r);
    endproperty
    a_prot: assert property (p_prot)
        else $error("write landed while protected");

    property p_attach_hold;
        @(posedge core_clk) disable iff (hard_rst)
        attach_wr_done_r |=> $stable(attach_r);
    endproperty
    a_attach_hold: assert property (p_attach_hold)
        else $error("attach changed after its one write");

    property p_attach_rst;
        @(posedge core_clk) sys_rst |=> attach_r && !attach_wr_done_r;
    endproperty
    a_attach_rst: assert property (p_attach_rst)
        else $error("attach not one after reset");

    property p_swap;
        @(posedge core_clk) disable iff (sys_rst)
        pin_swap_bits[0] |-> diff_plus_pin[0] == tx_dm[0]
            && diff_minus_pin[0] == tx_dp[0];
    endproperty
    a_swap: assert property (p_swap)
        else $error("upstream swap routing wrong");

    property p_rsvd;
        @(posedge core_clk) disable iff (sys_rst)
        up_boost_r[7:2] == 6'h00 && dn_boost_r[7:6] == 2'h0
            && dn_boost_r[1:0] == 2'h0 && remap3_r[7:4] == 4'h0
            && swap_r[7:4] == 4'h0 && !swap_r[1];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");

    property p_drive;
        @(posedge core_clk) disable iff (sys_rst)
        port2_boost_code == 2'h2 |-> port2_drive_sel == 4'h4;
    endproperty
    a_drive: assert property (p_drive)
        else $error("port 2 drive decode wrong");

    property p_std;
        @(posedge core_clk) disable iff (sys_rst)
        !remap_enable && std_port_disable == 3'h1 |->
            phys2_logical == 2'h1 && phys3_logical == 2'h2;
    endproperty
    a_std: assert property (p_std)
        else $error("standard mode did not shift ports down");

    property p_remap;
        @(posedge core_clk) disable iff (sys_rst)
        remap_enable && remap3_r[3:0] != 4'h0 && remap3_r[3:0] <= 4'h3
            |-> phys3_logical == remap3_r[1:0];
    endproperty
    a_remap: assert property (p_remap)
        else $error("remap table not applied");

    // Registered read data follows the address one edge late
    property p_rd_cmd;
        @(posedge core_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(cfg_addr) == hpcb_pkg::OFS_CMD |->
            cfg_rdata == {7'h00, $past(attach_r)};
    endproperty
    a_rd_cmd: assert property (p_rd_cmd)
        else $error("command register read wrong");

    property p_rd_unmapped;
        @(posedge core_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(cfg_addr) == 8'h30 |-> cfg_rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped address read not zero");

endmodule

// *** testbench/hpcb_phy_model.sv ***
// Transmitter-side partner: logical D+/D- levels for the three ports.
// Assumes the bench resets it with the bank and watches the routed pins.
`timescale 1ns/100ps
module hpcb_phy_model (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    output logic      [2:0] tx_dp,
    output logic      [2:0] tx_dm
);
    // ************************************************
    // Pattern source
    // ************************************************
    logic [2:0] pat_r;

    // Changes on the falling edge, away from the sampling edge
    always @(negedge core_clk) begin
        if (sys_rst) begin
            pat_r <= 3'h5;
        end else begin
            pat_r <= pat_r + 3'h3;
        end
    end

    // D- differs from D+ in a port-skewed way so a crossed pair shows
    assign tx_dp = pat_r;
    assign tx_dm = {pat_r[0], ~pat_r[2], pat_r[1]};
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the hub port configuration bank.
// Assumes the bank is write-protected from reset, as its attach default is one.
`timescale 1ns/100ps
module tb_top;
    // ************************************************
    // Signals
    // ************************************************
    logic       core_clk, sys_rst, external_reset_n, cfg_wr, remap_enable;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rd_v;
    logic [2:0] std_port_disable, tx_dp, tx_dm, pin_swap_bits;
    logic [2:0] diff_plus_pin, diff_minus_pin;
    logic [1:0] upstream_boost_code, port2_boost_code, port3_boost_code;
    logic [3:0] upstream_drive_sel, port2_drive_sel, port3_drive_sel;
    logic [3:0] remap_ports_one_two_field, remap_port_two_field;
    logic [3:0] remap_port_three_field;
    logic [1:0] phys1_logical, phys2_logical, phys3_logical;
    logic       usb_attach, config_state;
    int         n_errors, tests_run;
    logic [7:0] ofs [6];
    logic [7:0] dflt [6];

    hpcb_bank u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .external_reset_n(external_reset_n), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .remap_enable(remap_enable), .std_port_disable(std_port_disable),
        .upstream_boost_code(upstream_boost_code),
        .port2_boost_code(port2_boost_code),
        .port3_boost_code(port3_boost_code),
        .upstream_drive_sel(upstream_drive_sel),
        .port2_drive_sel(port2_drive_sel), .port3_drive_sel(port3_drive_sel),
        .pin_swap_bits(pin_swap_bits), .tx_dp(tx_dp), .tx_dm(tx_dm),
        .diff_plus_pin(diff_plus_pin), .diff_minus_pin(diff_minus_pin),
        .remap_ports_one_two_field(remap_ports_one_two_field),
        .remap_port_two_field(remap_port_two_field),
        .remap_port_three_field(remap_port_three_field),
        .phys1_logical(phys1_logical), .phys2_logical(phys2_logical),
        .phys3_logical(phys3_logical), .usb_attach(usb_attach),
        .config_state(config_state));

    hpcb_phy_model u_phy (.core_clk(core_clk), .sys_rst(sys_rst),
        .tx_dp(tx_dp), .tx_dm(tx_dm));

    // ************************************************
    // Tasks
    // ************************************************
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge core_clk);
        cfg_wr = 1'b0;
        // Idle edge so a following write never re-raises the strobe at once
        @(negedge core_clk);
    endtask

    // Read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cfg_addr = a;
        @(negedge core_clk);
        d = cfg_rdata;
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rd_v);
            check("register", rd_v, dflt[i]);
        end
        rd(8'h30, rd_v);
        check("unmapped", rd_v, 8'h00);
        check("attach", 8'(usb_attach), 8'h01);
        check("cfg state", 8'(config_state), 8'h00);
    endtask

    // Standard numbering: enabled ports counted upward in physical order
    task automatic check_std(input logic [2:0] dis);
        logic [1:0] n;
        logic [1:0] e [3];
        n = 2'h0;
        for (int i = 0; i < 3; i++) begin
            e[i] = dis[i] ? 2'h0 : n + 2'h1;
            n = dis[i] ? n : n + 2'h1;
        end
        std_port_disable = dis;
        @(negedge core_clk);
        check("phys1", 8'(phys1_logical), 8'(e[0]));
        check("phys2", 8'(phys2_logical), 8'(e[1]));
        check("phys3", 8'(phys3_logical), 8'(e[2]));
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************
    // Clock, watchdog, main sequence
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // The sequence takes some 270 cycles; the limit allows over five times that
    initial begin
        #7500;
        n_errors++;
        test_done();
    end

    initial begin
        ofs = '{hpcb_pkg::OFS_UP_BOOST, hpcb_pkg::OFS_DN_BOOST,
                hpcb_pkg::OFS_SWAP, hpcb_pkg::OFS_REMAP12,
                hpcb_pkg::OFS_REMAP3, hpcb_pkg::OFS_CMD};
        dflt = '{8'h00, 8'h00, 8'h00, 8'h21, 8'h03, 8'h01};
        n_errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        external_reset_n = 1'b1;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        remap_enable = 1'b1;
        std_port_disable = 3'h7;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        check_defaults();
        check("up sel", 8'(upstream_drive_sel), 8'h01);
        check("p2 sel", 8'(port2_drive_sel), 8'h01);
        check("p3 sel", 8'(port3_drive_sel), 8'h01);
        check("swap", 8'(pin_swap_bits), 8'h00);
        repeat (4) begin
            @(negedge core_clk);
            check("plus", 8'(diff_plus_pin), 8'(tx_dp));
            check("minus", 8'(diff_minus_pin), 8'(tx_dm));
        end
        // Default tables are contiguous, so the programmer side is kept
        check("map1", 8'(phys1_logical), 8'h01);
        check("map2", 8'(phys2_logical), 8'h02);
        check("map3", 8'(phys3_logical), 8'h03);
        check("fld hi", 8'(remap_port_two_field), 8'h02);
        check("fld lo", 8'(remap_ports_one_two_field), 8'h01);
        check("fld3", 8'(remap_port_three_field), 8'h03);
        remap_enable = 1'b0;
        for (int d = 0; d < 8; d++) begin
            check_std(3'(d));
        end
        // Protected bank: every write, soft reset and attach clear ignored
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'hFF);
            wr(ofs[i], 8'h12);
        end
        wr(hpcb_pkg::OFS_CMD, 8'h02);
        wr(hpcb_pkg::OFS_CMD, 8'h00);
        check("boost", 8'(upstream_boost_code), 8'h00);
        check("downstream_drive_boost", 8'({port3_boost_code, port2_boost_code}), 8'h00);
        check_defaults();
        // Pin reset passes the synchroniser and leaves the defaults
        // Pin held low 1 us, its minimum assertion width
        external_reset_n = 1'b0;
        repeat (200) @(negedge core_clk);
        external_reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check_defaults();
        test_done();
    end
endmodule
